// [src/mct_top.sv]
//
// Behaviour
// - Clock-out enable drives the CPU clock on the clock-out pin in slow mode, half the CPU clock otherwise.
// - Clock-out is suspended during timed low-power halt.
// - Slow divider codes select oscillator divided by 2, 4, 8, 16.
// - Slow mode select off gives CPU clock equal to oscillator.
// - Time base codes give 16000, 32000, 80000, 200000 cycle periods.
// - New time base length applies only from the next period.
// - Tick interrupt enable allows the request and wakes timed halt.
// - Halt with tick interrupt enabled enters timed halt, not full halt.
// - Tick flag set each period; cleared by reading control/status.
// - Tone codes: off, about 2 kHz, 1 kHz, 500 Hz square waves.
// - Tone keeps running during timed low-power halt.
// - Reset clears both registers to zero.
// - Interrupt request only with enable set and CPU mask inactive.
// - Full halt freezes counter and registers until a wake interrupt.
//
`timescale 1ns/10ps
`include "mct_defs.svh"

module mct_top #(
    parameter int unsigned TB_COUNT_0    = `MCT_TB_COUNT_0,
    parameter int unsigned TB_COUNT_1    = `MCT_TB_COUNT_1,
    parameter int unsigned TB_COUNT_2    = `MCT_TB_COUNT_2,
    parameter int unsigned TB_COUNT_3    = `MCT_TB_COUNT_3,
    parameter int unsigned TONE_PERIOD_1 = `MCT_TONE_PERIOD_1,
    parameter int unsigned TONE_PERIOD_2 = `MCT_TONE_PERIOD_2,
    parameter int unsigned TONE_PERIOD_3 = `MCT_TONE_PERIOD_3
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              halt_request,
    input  wire logic              wake_interrupt,
    input  wire logic              cpu_int_mask,
    output logic                   cpu_clk_en,
    output logic                   clock_out_pin,
    output logic                   clock_out_oe_n,
    output logic                   tone_pin,
    output logic                   tone_oe_n,
    output logic                   tick_irq,
    output mct_pkg::mct_mode_t     power_mode
);
    import mct_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mct_mode_t   mode_q;
    logic        clock_out_enable_q;
    logic [1:0]  slow_divider_select_q;
    logic        slow_mode_select_q;
    logic [1:0]  time_base_select_q;
    logic        tick_interrupt_enable_q;
    logic        tick_flag_q;
    logic [1:0]  tone_select_q;
    logic [17:0] tb_last_q;
    logic [12:0] tone_last_q;
    logic        tone_level_q;
    logic        clk_out_level_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        cpu_clk_en_q;
    logic        clock_out_oe_n_q;
    logic        tone_oe_n_q;
    logic        tick_irq_q;

    logic        setup;
    logic        access;
    logic        wr_csr;
    logic        wr_tone;
    logic        rd_csr;
    logic        hit_csr;
    logic        hit_tone;
    logic [7:0]  csr_view;
    logic [3:0]  cpu_last;
    logic [3:0]  cpu_count;
    logic        cpu_wrap;
    logic [17:0] tb_next_last;
    logic        tb_wrap;
    logic        tone_wrap;
    logic        running;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready_q;
    assign hit_csr  = (paddr == `MCT_ADDR_CLOCK_CONTROL_STATUS);
    assign hit_tone = (paddr == `MCT_ADDR_TONE_CONTROL);
    assign running  = (mode_q == MCT_RUN);
    // Halted CPU cannot program us; writes in halt are dropped
    assign wr_csr   = access & pwrite & hit_csr & running;
    assign wr_tone  = access & pwrite & hit_tone & running;
    assign rd_csr   = access & ~pwrite & hit_csr;

    assign csr_view = {clock_out_enable_q, slow_divider_select_q, slow_mode_select_q,
                       time_base_select_q, tick_interrupt_enable_q, tick_flag_q};

    // One wait-free access phase: answer is prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~(hit_csr | hit_tone);
            if (hit_csr) begin
                prdata_q <= {24'h00_0000, csr_view};
            end else if (hit_tone) begin
                prdata_q <= {30'h0000_0000, tone_select_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end else if (access) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_enable_q      <= 1'b0;
            slow_divider_select_q   <= 2'h0;
            slow_mode_select_q      <= 1'b0;
            time_base_select_q      <= 2'h0;
            tick_interrupt_enable_q <= 1'b0;
        end else if (wr_csr) begin
            clock_out_enable_q      <= pwdata[`MCT_BIT_CLOCK_OUT_ENABLE];
            slow_divider_select_q   <= pwdata[`MCT_FLD_SLOW_DIVIDER_HI:`MCT_FLD_SLOW_DIVIDER_LO];
            slow_mode_select_q      <= pwdata[`MCT_BIT_SLOW_MODE_SELECT];
            time_base_select_q      <= pwdata[`MCT_FLD_TIME_BASE_HI:`MCT_FLD_TIME_BASE_LO];
            tick_interrupt_enable_q <= pwdata[`MCT_BIT_TICK_INTERRUPT_ENABLE];
        end
    end

    // Reserved tone bits are not stored and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_select_q <= `MCT_RST_TONE_CONTROL;
        end else if (wr_tone) begin
            tone_select_q <= pwdata[`MCT_FLD_TONE_HI:`MCT_FLD_TONE_LO];
        end
    end

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MCT_RUN;
        end else begin
            case (mode_q)
                MCT_RUN: begin
                    if (halt_request) begin
                        mode_q <= tick_interrupt_enable_q ? MCT_ACTIVE_HALT : MCT_FULL_HALT;
                    end
                end
                MCT_ACTIVE_HALT: begin
                    if (wake_interrupt | (tb_wrap & tick_interrupt_enable_q)) begin
                        mode_q <= MCT_RUN;
                    end
                end
                MCT_FULL_HALT: begin
                    if (wake_interrupt) begin
                        mode_q <= MCT_RUN;
                    end
                end
                default: begin
                    mode_q <= MCT_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // CPU clock prescaler and clock-out
    // ------------------------------------------------------------
    // divide by 2^(code+1) only in slow mode
    assign cpu_last = slow_mode_select_q ?
                      4'((5'h02 << slow_divider_select_q) - 5'h01) : 4'h0;

    mct_divider #(.W(4)) u_cpu_div (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (running),
        .clear (~running),
        .last  (cpu_last),
        .count (cpu_count),
        .wrap  (cpu_wrap)
    );

    // CPU clock stops in either halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en_q <= 1'b0;
        end else begin
            cpu_clk_en_q <= cpu_wrap;
        end
    end

    // Full rate can only be shown as a half-rate toggle from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_level_q <= 1'b0;
        end else if (!running) begin
            clk_out_level_q <= 1'b0;
        end else if (slow_mode_select_q) begin
            clk_out_level_q <= (cpu_count < (4'h1 << slow_divider_select_q));
        end else begin
            clk_out_level_q <= ~clk_out_level_q;
        end
    end

    // drive only when enabled and not halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_oe_n_q <= 1'b1;
        end else begin
            clock_out_oe_n_q <= ~(clock_out_enable_q & running);
        end
    end

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // period table
    always_comb begin
        case (time_base_select_q)
            2'h0:    tb_next_last = 18'(TB_COUNT_0 - 1);
            2'h1:    tb_next_last = 18'(TB_COUNT_1 - 1);
            2'h2:    tb_next_last = 18'(TB_COUNT_2 - 1);
            default: tb_next_last = 18'(TB_COUNT_3 - 1);
        endcase
    end

    // length latched only at period end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_last_q <= 18'(TB_COUNT_0 - 1);
        end else if (tb_wrap) begin
            tb_last_q <= tb_next_last;
        end
    end

    // frozen in full halt, free running otherwise
    mct_divider #(.W(18)) u_tb_div (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (mode_q != MCT_FULL_HALT),
        .clear (1'b0),
        .last  (tb_last_q),
        .count (),
        .wrap  (tb_wrap)
    );

    // set beats the read clear; only a flag that was read is cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_flag_q <= 1'b0;
        end else if (tb_wrap) begin
            tick_flag_q <= 1'b1;
        end else if (rd_csr & prdata_q[`MCT_BIT_TICK_FLAG]) begin
            tick_flag_q <= 1'b0;
        end
    end

    // request gated by enable and CPU mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_irq_q <= 1'b0;
        end else begin
            tick_irq_q <= tick_flag_q & tick_interrupt_enable_q & ~cpu_int_mask;
        end
    end

    // ------------------------------------------------------------
    // Tone generator
    // ------------------------------------------------------------
    // half period per tone code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_last_q <= 13'h0000;
        end else begin
            case (tone_select_q)
                2'h1:    tone_last_q <= 13'(TONE_PERIOD_1 / 2 - 1);
                2'h2:    tone_last_q <= 13'(TONE_PERIOD_2 / 2 - 1);
                2'h3:    tone_last_q <= 13'(TONE_PERIOD_3 / 2 - 1);
                default: tone_last_q <= 13'h0000;
            endcase
        end
    end

    // keeps running in timed halt, stops in full halt
    mct_divider #(.W(13)) u_tone_div (
        .clk   (pclk),
        .rst_n (presetn),
        .en    ((tone_select_q != 2'h0) & (mode_q != MCT_FULL_HALT)),
        .clear (tone_select_q == 2'h0),
        .last  (tone_last_q),
        .count (),
        .wrap  (tone_wrap)
    );

    // Square wave, about 50% duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_level_q <= 1'b0;
            tone_oe_n_q  <= 1'b1;
        end else begin
            tone_oe_n_q <= (tone_select_q == 2'h0);
            if (tone_select_q == 2'h0) begin
                tone_level_q <= 1'b0;
            end else if (tone_wrap) begin
                tone_level_q <= ~tone_level_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign cpu_clk_en     = cpu_clk_en_q;
    assign clock_out_pin  = clk_out_level_q;
    assign clock_out_oe_n = clock_out_oe_n_q;
    assign tone_pin       = tone_level_q;
    assign tone_oe_n      = tone_oe_n_q;
    assign tick_irq       = tick_irq_q;
    assign power_mode     = mode_q;

endmodule // mct_top

// [common/mct_defs.svh]
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MCT_IDX_CLOCK_CONTROL_STATUS 8'h2C
`define MCT_IDX_TONE_CONTROL         8'h2D
`define MCT_ADDR_CLOCK_CONTROL_STATUS 8'hB0
`define MCT_ADDR_TONE_CONTROL         8'hB4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCT_BIT_CLOCK_OUT_ENABLE      7
`define MCT_FLD_SLOW_DIVIDER_HI       6
`define MCT_FLD_SLOW_DIVIDER_LO       5
`define MCT_BIT_SLOW_MODE_SELECT      4
`define MCT_FLD_TIME_BASE_HI          3
`define MCT_FLD_TIME_BASE_LO          2
`define MCT_BIT_TICK_INTERRUPT_ENABLE 1
`define MCT_BIT_TICK_FLAG             0
`define MCT_FLD_TONE_HI               1
`define MCT_FLD_TONE_LO               0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCT_RST_CLOCK_CONTROL_STATUS 8'h00
`define MCT_RST_TONE_CONTROL         2'h0

// ----------------------------------------------------------------
// Timing counts in oscillator cycles
// ----------------------------------------------------------------
`define MCT_TB_COUNT_0 16000
`define MCT_TB_COUNT_1 32000
`define MCT_TB_COUNT_2 80000
`define MCT_TB_COUNT_3 200000
// Full tone periods: 8 MHz over 2 kHz, 1 kHz and 500 Hz
`define MCT_TONE_PERIOD_1 4000
`define MCT_TONE_PERIOD_2 8000
`define MCT_TONE_PERIOD_3 16000

`endif

// [common/mct_pkg.sv]
package mct_pkg;

    // Power state seen by the clock controller
    typedef enum logic [1:0] {
        MCT_RUN,
        MCT_ACTIVE_HALT,
        MCT_FULL_HALT
    } mct_mode_t;

endpackage

// [src/mct_divider.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Enabled up-counter that wraps after reaching last
// ----------------------------------------------------------------
module mct_divider #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic         clear,
    input  wire logic [W-1:0] last,
    output logic      [W-1:0] count,
    output logic              wrap
);

    logic [W-1:0] count_q;

    // Compare with >= so a shortened limit never strands the count
    assign wrap  = en & (count_q >= last);
    assign count = count_q;

    // Count state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (wrap) begin
            count_q <= '0;
        end else if (en) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // mct_divider

// [verif/mct_top_props.sv]
`timescale 1ns/10ps
module mct_top_props (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               halt_request,
    input wire logic               wake_interrupt,
    input wire logic               cpu_int_mask,
    input wire logic               cpu_clk_en,
    input wire logic               clock_out_pin,
    input wire logic               clock_out_oe_n,
    input wire logic               tone_pin,
    input wire logic               tone_oe_n,
    input wire logic               tick_irq,
    input wire mct_pkg::mct_mode_t power_mode
);
    import mct_pkg::*;
    // ------------------------------------------------
    // Port relations
    // ------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Zero wait states, one-cycle answer
    a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'hB0, 8'hB4}))
        else $error("pslverr does not match the address map");
    a_clkout_halt: assert property (power_mode == MCT_ACTIVE_HALT [*2] |-> clock_out_oe_n && !clock_out_pin)
        else $error("clock-out active in timed halt");
    // Normal speed output shows a toggling clock
    a_clkout_toggle: assert property ((cpu_clk_en && !clock_out_oe_n) [*3] |-> clock_out_pin != $past(clock_out_pin))
        else $error("clock-out pin not toggling");
    a_irq_mask: assert property (tick_irq |-> !$past(cpu_int_mask))
        else $error("tick interrupt raised while masked");
    a_halt_enter: assert property (power_mode == MCT_RUN && halt_request && !wake_interrupt |=> power_mode != MCT_RUN)
        else $error("halt request ignored");
    a_full_hold: assert property (power_mode == MCT_FULL_HALT && !wake_interrupt |=> power_mode == MCT_FULL_HALT)
        else $error("full halt left without wake");
    // Oscillator stopped, so the tone must not move
    a_tone_frozen: assert property (power_mode == MCT_FULL_HALT [*3] |-> $stable(tone_pin))
        else $error("tone moved in full halt");
    a_read_clear: assert property (pready && !pwrite && !pslverr && paddr == 8'hB0 && prdata[0] |-> ##2 !tick_irq)
        else $error("flag read did not clear request");

    c_timed_wake: cover property (power_mode == MCT_ACTIVE_HALT ##1 power_mode == MCT_RUN);
    c_slverr: cover property (pready && pslverr);
    c_tick: cover property ($rose(tick_irq));
endmodule // mct_top_props

bind mct_top mct_top_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_request(halt_request), .wake_interrupt(wake_interrupt), .cpu_int_mask(cpu_int_mask),
    .cpu_clk_en(cpu_clk_en), .clock_out_pin(clock_out_pin), .clock_out_oe_n(clock_out_oe_n),
    .tone_pin(tone_pin), .tone_oe_n(tone_oe_n), .tick_irq(tick_irq), .power_mode(power_mode));

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
    import mct_pkg::*;
    // Short counts keep the run brief
    localparam int TBP[4] = '{16, 32, 80, 200};
    localparam int TNP[4] = '{0, 8, 16, 32};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic        halt_request, wake_interrupt, cpu_int_mask, cpu_clk_en, tick_irq;
    logic        clock_out_pin, clock_out_oe_n, tone_pin, tone_oe_n, irq_d, tone_d;
    logic [7:0]  paddr, wv;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] lfsr_q = 32'h00010CB2;
    mct_mode_t   power_mode;
    int          miscompares, cmp_count, cyc, last, per, rises, tlast, tper, n, m, i, c, pc;

    mct_top #(.TB_COUNT_0(TBP[0]), .TB_COUNT_1(TBP[1]), .TB_COUNT_2(TBP[2]), .TB_COUNT_3(TBP[3]),
        .TONE_PERIOD_1(TNP[1]), .TONE_PERIOD_2(TNP[2]), .TONE_PERIOD_3(TNP[3])) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_request(halt_request), .wake_interrupt(wake_interrupt), .cpu_int_mask(cpu_int_mask),
        .cpu_clk_en(cpu_clk_en), .clock_out_pin(clock_out_pin), .clock_out_oe_n(clock_out_oe_n),
        .tone_pin(tone_pin), .tone_oe_n(tone_oe_n), .tick_irq(tick_irq), .power_mode(power_mode));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Processor enables seen in a 64-cycle window
    function automatic int slow_en(input int code);
        return code < 4 ? 64 >> (code + 1) : 64;
    endfunction

    // ------------------------------------------------
    // Watchers: tick spacing, tone half period, timeout
    // ------------------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (tick_irq === 1'b1 && !irq_d) begin
            per = cyc - last;
            last = cyc;
            rises++;
        end
        if (tone_pin !== tone_d) begin
            tper = cyc - tlast;
            tlast = cyc;
        end
        irq_d = (tick_irq === 1'b1);
        tone_d = tone_pin;
        if (cyc > 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s exp=%h got=%h", nm, exp, got);
        end
    endtask

    // One APB transfer; upper data bits carry random filler
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        lfsr_q = lfsr_next(lfsr_q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        // whole-byte writes only; reserved bits 31:8 of either register carry random filler
        pwdata <= {lfsr_q[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: only the cycle ceiling ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_rise;
        int r, k;
        r = rises;
        k = 0;
        while (rises == r && k < 1000) begin
            @(posedge pclk);
            k++;
        end
    endtask

    task end_of_test;
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        halt_request = 1'b0;
        wake_interrupt = 1'b0;
        cpu_int_mask = 1'b0;
        irq_d = 1'b0;
        tone_d = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe_rst", {clock_out_oe_n, tone_oe_n}, 32'h3);
        apb(1'b0, 8'hB0, 8'h00);
        chk("ccs_rst", rd, 32'h0);
        apb(1'b0, 8'hB4, 8'h00);
        chk("tone_rst", rd, 32'h0);
        apb(1'b0, 8'hC0, 8'h00);
        chk("unmapped", {slv, rd[30:0]}, 32'h80000000);
        // Each new length must wait for the running period
        apb(1'b1, 8'hB0, 8'h02);
        wait_rise();
        apb(1'b0, 8'hB0, 8'h00);
        pc = 0;
        for (i = 0; i < 4; i++) begin
            c = (i * 3 + 1) % 4;
            apb(1'b1, 8'hB0, 8'(c * 4 + 2));
            wait_rise();
            chk("old_len", per, TBP[pc]);
            apb(1'b0, 8'hB0, 8'h00);
            chk("flag_rd", rd, c * 4 + 3);
            wait_rise();
            chk("new_len", per, TBP[c]);
            apb(1'b0, 8'hB0, 8'h00);
            pc = c;
        end
        apb(1'b1, 8'hB0, 8'h00);
        repeat (100) @(posedge pclk);
        chk("irq_dis", tick_irq, 0);
        cpu_int_mask <= 1'b1;
        apb(1'b1, 8'hB0, 8'h02);
        repeat (3) @(posedge pclk);
        chk("irq_msk", tick_irq, 0);
        cpu_int_mask <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq_on", tick_irq, 1);
        // Prescaler codes, time base random; tick enable off, and the read check skips tick flag bit 0
        for (c = 0; c < 5; c++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wv = {1'b1, c[1:0], c < 4, lfsr_q[3:2], 2'b00};
            apb(1'b1, 8'hB0, wv);
            repeat (20) @(posedge pclk);
            n = 0;
            m = 0;
            repeat (64) begin
                @(posedge pclk);
                if (cpu_clk_en === 1'b1) n++;
                if (clock_out_pin === 1'b1) m++;
            end
            chk("cpu_en", n, slow_en(c));
            chk("co_duty", m, 32);
            chk("co_oe", clock_out_oe_n, 0);
            apb(1'b0, 8'hB0, 8'h00);
            chk("ccs_rd", rd[7:1], wv[7:1]);
        end
        for (c = 0; c < 4; c++) begin
            apb(1'b1, 8'hB4, 8'(c));
            repeat (40) @(posedge pclk);
            chk("tone_oe", tone_oe_n, c == 0);
            if (c == 0) chk("tone_off", tone_pin, 0);
            else chk("tone_half", tper, TNP[c] / 2);
            apb(1'b0, 8'hB4, 8'h00);
            chk("tone_rd", rd, c);
        end
        // Clear a stale flag with the enable off, so the wait below sees a fresh tick
        apb(1'b1, 8'hB4, 8'h01);
        apb(1'b1, 8'hB0, 8'h80);
        apb(1'b0, 8'hB0, 8'h00);
        // Timed halt soon after a tick, so the check lands mid-period
        apb(1'b1, 8'hB0, 8'h82);
        wait_rise();
        apb(1'b0, 8'hB0, 8'h00);
        halt_request <= 1'b1;
        @(posedge pclk);
        halt_request <= 1'b0;
        tper = 0;
        repeat (6) @(posedge pclk);
        chk("mode_ah", power_mode, MCT_ACTIVE_HALT);
        chk("co_off", clock_out_oe_n, 1);
        chk("tone_ah", tper, TNP[1] / 2);
        wait_rise();
        repeat (2) @(posedge pclk);
        chk("wake_tick", power_mode, MCT_RUN);
        apb(1'b1, 8'hB0, 8'h80);
        halt_request <= 1'b1;
        @(posedge pclk);
        halt_request <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("mode_fh", power_mode, MCT_FULL_HALT);
        apb(1'b1, 8'hB4, 8'h03);
        wake_interrupt <= 1'b1;
        @(posedge pclk);
        wake_interrupt <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("wake_ext", power_mode, MCT_RUN);
        apb(1'b0, 8'hB4, 8'h00);
        chk("frozen", rd, 1);
        end_of_test();
    end
endmodule // tb
